// File: logic/siu_defines.vh
// register offsets, field positions, reset values and timing counts
`ifndef SIU_DEFINES_VH
`define SIU_DEFINES_VH
`define SIU_OFS_BREAK_WAKE   8'h00
`define SIU_OFS_RESET_CAUSE  8'h04
`define SIU_OFS_BREAK_FLAG   8'h08
`define SIU_OFS_CONFIG       8'h0c
`define SIU_OFS_STATUS       8'h10
`define SIU_BIT_WAKE_FLAG    1
`define SIU_BIT_CLEAR_EN     7
`define SIU_BIT_SHORT_REC    0
`define SIU_BIT_WDOG_DIS     1
`define SIU_RST_BREAK_WAKE   8'h00
`define SIU_RST_BREAK_FLAG   8'h00
`define SIU_RST_CONFIG       8'h00
`define SIU_CAUSE_POWER_ON   6'h01
`define SIU_REC_LONG_CYC     4096
`define SIU_REC_SHORT_CYC    32
`define SIU_CNT_W            12
`endif

// File: logic/siu_recovery_counter.v
// stop recovery counter, 13 bits, clocked on the falling oscillator edge
`timescale 1ns/1ns
`default_nettype none
`include "siu_defines.vh"
module siu_recovery_counter #(
   parameter LONG_CYC = `SIU_REC_LONG_CYC,
   parameter W        = `SIU_CNT_W
) (
   input  wire         clk,
   input  wire         rst_n,
   input  wire         holdClear,
   input  wire         shortSel,
   output reg          done
);
   localparam [W:0] LONG_T  = LONG_CYC;
   localparam [W:0] SHORT_T = `SIU_REC_SHORT_CYC;
   reg  [W:0]   count_reg;
   wire [W:0]   target;
   assign target = shortSel ? SHORT_T : LONG_T;
   // held clear during stop, counts once recovery starts
   always @(negedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count_reg <= {(W+1){1'b0}};
         done      <= 1'b0;
      end else if (holdClear) begin
         count_reg <= {(W+1){1'b0}};
         done      <= 1'b0;
      end else if (count_reg < target) begin
         count_reg <= count_reg + 1'b1;
         done      <= (count_reg + 1'b1 == target);
      end
   end
endmodule
`default_nettype wire

// File: logic/siu_core.v
// system integration unit: interrupt sequencing, break, low power, status registers
//
// What this block does
// - hardware interrupts are checked only when the current instruction ends
// - service only when mask clear and source enabled, else fetch next
// - highest priority pending interrupt is serviced first
// - interrupt pending at return is serviced before next program instruction
// - entry stacking skips the index high register
// - software interrupt instruction always interrupts, ignoring the mask
// - software interrupt stacks pc, hardware interrupt stacks pc minus one
// - reset beats every interrupt and is never arbitrated
// - break request forces processor to the software interrupt vector
// - in break, flag clearing blocked unless break clear enable set
// - a flag cleared in break stays cleared after break
// - two-step clears protected in break, second step after exit clears
// - wait and stop clear the interrupt mask and stop processor clock
// - wait stops processor clock only; interrupt, reset or break ends it
// - wake from wait starts stacking one cycle after the synchronised interrupt or break
// - break during wait or stop sets the break wake flag
// - watchdog stays running in wait when watchdog disable is zero
// - stop resets recovery counter and gates all three clock outputs
// - recovery lasts 4096 cycles, or 32 with short recovery selected
// - counter held until recovery begins; stacking waits for its end
// - break wake flag readable, cleared by writing zero
// - reset cause register holds six source flags, clears on read
// - a latched interrupt is not displaced until serviced or no request is pending with mask clear
// - recovery counter is 13 bits on the falling oscillator edge
//
// Local design decisions: the AHB-Lite register port and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "siu_defines.vh"
module siu_core #(
   parameter NSRC     = 8,
   parameter LONG_CYC = `SIU_REC_LONG_CYC
) (
   input  wire            clk,
   input  wire            rst_n,
   input  wire            haddr_sel,
   input  wire [31:0]     haddr,
   input  wire [1:0]      htrans,
   input  wire            hwrite,
   input  wire [2:0]      hsize,
   input  wire [31:0]     hwdata,
   input  wire            hready,
   output reg  [31:0]     hrdata,
   output reg             hreadyout,
   output reg             hresp,
   input  wire            instrDone,
   input  wire            swiExec,
   input  wire            waitExec,
   input  wire            stopExec,
   input  wire            rtiExec,
   input  wire            cpuMask,
   input  wire            stackDone,
   input  wire [NSRC-1:0] irqReq,
   input  wire [NSRC-1:0] irqEn,
   input  wire            breakReq,
   input  wire [5:0]      resetCause,
   input  wire            sysReset,
   input  wire            flagClrStep1,
   input  wire            flagClrStep2,
   output reg             intStart,
   output reg  [3:0]      intVector,
   output reg             stackPcMinus1,
   output reg             stackIndexHigh,
   output reg             maskClear,
   output reg             cpuClkEn,
   output reg             periphClkEn,
   output reg             oscClkEn,
   output reg             watchdogRun,
   output reg             breakState,
   output reg             flagClrAllow,
   output reg             resetSeq
);
   localparam S_RUN  = 3'h0;
   localparam S_WAIT = 3'h1;
   localparam S_STOP = 3'h2;
   localparam S_REC  = 3'h3;
   localparam S_STK  = 3'h4;
   localparam [3:0] SWI_VEC = 4'hf;

   // synchronisers for pins from outside
   reg  [NSRC-1:0] irqS1_reg, irqS2_reg;
   reg             brkS1_reg, brkS2_reg, rstS1_reg, rstS2_reg;
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irqS1_reg <= {NSRC{1'b0}};
         irqS2_reg <= {NSRC{1'b0}};
         brkS1_reg <= 1'b0;
         brkS2_reg <= 1'b0;
         rstS1_reg <= 1'b0;
         rstS2_reg <= 1'b0;
      end else begin
         irqS1_reg <= irqReq;
         irqS2_reg <= irqS1_reg;
         brkS1_reg <= breakReq;
         brkS2_reg <= brkS1_reg;
         rstS1_reg <= sysReset;
         rstS2_reg <= rstS1_reg;
      end
   end

   // lowest index wins
   function [3:0] prio;
      input [NSRC-1:0] v;
      integer i;
      begin
         prio = 4'h0;
         for (i = NSRC - 1; i >= 0; i = i - 1) begin
            if (v[i]) begin
               prio = i[3:0];
            end
         end
      end
   endfunction

   // write data phase hit on one register
   function wrHit;
      input       pend;
      input       wr;
      input [7:0] addr;
      input [7:0] ofs;
      begin
         wrHit = pend && wr && (addr == ofs);
      end
   endfunction

   reg  [2:0]  state_reg, state_next;
   reg         latched_reg;
   reg  [3:0]  latchVec_reg;
   reg         shortRec_reg, wdogDis_reg, clearEn_reg, wakeFlag_reg;
   reg  [5:0]  cause_reg;
   reg         step1_reg;
   reg         aPend_reg, aWrite_reg;
   reg  [7:0]  aAddr_reg;
   wire        recDone;
   wire [NSRC-1:0] live;
   wire        anyLive;
   assign live    = irqS2_reg & irqEn;
   assign anyLive = |live;

   siu_recovery_counter #(
      .LONG_CYC (LONG_CYC),
      .W        (`SIU_CNT_W)
   ) uRec (
      .clk       (clk),
      .rst_n     (rst_n),
      .holdClear (state_reg != S_REC),
      .shortSel  (shortRec_reg),
      .done      (recDone)
   );

   always @* begin
      state_next = state_reg;
      case (state_reg)
         S_RUN: begin
            if (brkS2_reg) begin
               state_next = S_STK;
            end else if (waitExec) begin
               state_next = S_WAIT;
            end else if (stopExec) begin
               state_next = S_STOP;
            end else if (instrDone && (swiExec || (anyLive && !cpuMask) || latched_reg)) begin
               state_next = S_STK;
            end
         end
         S_WAIT: begin
            if (anyLive || brkS2_reg) begin
               state_next = S_STK;
            end
         end
         S_STOP: begin
            if (anyLive || brkS2_reg) begin
               state_next = S_REC;
            end
         end
         S_REC: begin
            if (recDone) begin
               state_next = S_STK;
            end
         end
         S_STK: begin
            if (stackDone) begin
               state_next = S_RUN;
            end
         end
         default: state_next = S_RUN;
      endcase
      if (rstS2_reg) begin
         state_next = S_RUN;
      end
   end

   wire busGo = haddr_sel && htrans[1] && hready;
   wire rdCause = aPend_reg && !aWrite_reg && aAddr_reg == `SIU_OFS_RESET_CAUSE;

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg      <= S_RUN;
         latched_reg    <= 1'b0;
         latchVec_reg   <= 4'h0;
         intStart       <= 1'b0;
         intVector      <= 4'h0;
         stackPcMinus1  <= 1'b0;
         stackIndexHigh <= 1'b0;
         maskClear      <= 1'b0;
         cpuClkEn       <= 1'b1;
         periphClkEn    <= 1'b1;
         oscClkEn       <= 1'b1;
         watchdogRun    <= 1'b1;
         breakState     <= 1'b0;
         resetSeq       <= 1'b0;
         flagClrAllow   <= 1'b1;
         step1_reg      <= 1'b0;
         shortRec_reg   <= 1'b0;
         wdogDis_reg    <= 1'b0;
         clearEn_reg    <= 1'b0;
         wakeFlag_reg   <= 1'b0;
         cause_reg      <= `SIU_CAUSE_POWER_ON;
         aPend_reg      <= 1'b0;
         aWrite_reg     <= 1'b0;
         aAddr_reg      <= 8'h00;
         hrdata         <= 32'h0000_0000;
         hreadyout      <= 1'b1;
         hresp          <= 1'b0;
      end else begin
         state_reg <= state_next;
         resetSeq  <= rstS2_reg;
         // latch the winner once, hold it until serviced or until no request is pending with mask clear
         if (rstS2_reg || stackDone || (!cpuMask && !anyLive)) begin
            latched_reg <= 1'b0;
         end else if (!latched_reg && anyLive && !cpuMask) begin
            latched_reg  <= 1'b1;
            latchVec_reg <= prio(live);
         end
         intStart <= (state_next == S_STK) && (state_reg != S_STK) && !rstS2_reg;
         if ((state_next == S_STK) && (state_reg != S_STK)) begin
            if (brkS2_reg || (state_reg == S_RUN && swiExec)) begin
               intVector     <= SWI_VEC;
               stackPcMinus1 <= 1'b0;
            end else begin
               intVector     <= latched_reg ? latchVec_reg : prio(live);
               stackPcMinus1 <= 1'b1;
            end
            if (brkS2_reg) begin
               breakState <= 1'b1;
            end
         end
         if (rtiExec || rstS2_reg) begin
            breakState <= 1'b0;
         end
         stackIndexHigh <= 1'b0;
         maskClear <= (waitExec || stopExec) && state_reg == S_RUN;
         cpuClkEn    <= (state_next == S_RUN) || (state_next == S_STK);
         periphClkEn <= (state_next != S_STOP) && (state_next != S_REC);
         oscClkEn    <= (state_next != S_STOP);
         watchdogRun <= (state_next == S_RUN) || (state_next == S_STK) ||
                        ((state_next == S_WAIT) && !wdogDis_reg);
         // two-step clear held off in break until second step after exit
         if (flagClrStep1) begin
            step1_reg <= 1'b1;
         end else if (flagClrStep2 && flagClrAllow) begin
            step1_reg <= 1'b0;
         end
         flagClrAllow <= !breakState || clearEn_reg;
         // bus slave
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         if (hready) begin
            aPend_reg  <= busGo;
            aWrite_reg <= hwrite;
            aAddr_reg  <= haddr[7:0];
         end
         if (busGo && !hwrite) begin
            case (haddr[7:0])
               `SIU_OFS_BREAK_WAKE:  hrdata <= {30'h0, wakeFlag_reg, 1'b0};
               `SIU_OFS_RESET_CAUSE: hrdata <= {26'h0, cause_reg};
               `SIU_OFS_BREAK_FLAG:  hrdata <= {24'h0, clearEn_reg, 7'h00};
               `SIU_OFS_CONFIG:      hrdata <= {30'h0, wdogDis_reg, shortRec_reg};
               `SIU_OFS_STATUS:      hrdata <= {26'h0, step1_reg, state_reg, latched_reg,
                                                breakState};
               default:              hrdata <= 32'h0000_0000;
            endcase
         end
         if (aPend_reg && aWrite_reg) begin
            case (aAddr_reg)
               `SIU_OFS_BREAK_FLAG: clearEn_reg <= hwdata[`SIU_BIT_CLEAR_EN];
               `SIU_OFS_CONFIG: begin
                  shortRec_reg <= hwdata[`SIU_BIT_SHORT_REC];
                  wdogDis_reg  <= hwdata[`SIU_BIT_WDOG_DIS];
               end
               default: ;
            endcase
         end
         // set wins over a write of zero
         if (brkS2_reg && (state_reg == S_WAIT || state_reg == S_STOP ||
                           state_reg == S_REC)) begin
            wakeFlag_reg <= 1'b1;
         end else if (wrHit(aPend_reg, aWrite_reg, aAddr_reg, `SIU_OFS_BREAK_WAKE) &&
                      !hwdata[`SIU_BIT_WAKE_FLAG]) begin
            wakeFlag_reg <= 1'b0;
         end
         if (rstS2_reg) begin
            cause_reg <= resetCause;
         end else if (rdCause) begin
            cause_reg <= 6'h00;
         end
      end
   end
endmodule
`default_nettype wire

// File: dv/siu_core_sva.sv
// checker for the system integration unit ports
`timescale 1ns/1ns
`default_nettype none
module siu_core_sva (
   input wire logic       clk,
   input wire logic       rst_n,
   input wire logic       hreadyout,
   input wire logic       hresp,
   input wire logic       instrDone,
   input wire logic       swiExec,
   input wire logic       waitExec,
   input wire logic       stopExec,
   input wire logic       cpuMask,
   input wire logic       sysReset,
   input wire logic       intStart,
   input wire logic [3:0] intVector,
   input wire logic       stackPcMinus1,
   input wire logic       stackIndexHigh,
   input wire logic       maskClear,
   input wire logic       cpuClkEn,
   input wire logic       periphClkEn,
   input wire logic       oscClkEn,
   input wire logic       breakState,
   input wire logic       flagClrAllow,
   input wire logic       resetSeq
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_bus_okay: assert property (hreadyout && !hresp)
      else $error("bus not ready or not okay");
   a_swi_entry: assert property (instrDone && swiExec && !sysReset && !resetSeq
      |=> intStart && intVector == 4'hf && !stackPcMinus1) else $error("swi entry bad");
   a_no_index_high: assert property (!stackIndexHigh)
      else $error("index high stacked");
   a_hw_unmasked: assert property (intStart && stackPcMinus1
      |-> !$past(cpuMask) && intVector != 4'hf) else $error("hw entry bad");
   a_wait_gate: assert property (waitExec && !sysReset
      |=> !cpuClkEn && periphClkEn && maskClear) else $error("wait entry bad");
   a_stop_gate: assert property (stopExec && !sysReset
      |=> !periphClkEn && !oscClkEn && maskClear) else $error("stop entry bad");
   a_reset_seq: assert property ($rose(sysReset) |-> ##[1:4] resetSeq)
      else $error("reset not followed");
   a_reset_wins: assert property (resetSeq |-> !intStart)
      else $error("entry during reset");
   a_flag_free: assert property (!breakState && !$past(breakState) && $past(rst_n)
      && !resetSeq |-> flagClrAllow) else $error("clear blocked outside break");
endmodule
bind siu_core siu_core_sva siu_core_sva_inst (.clk(clk), .rst_n(rst_n),
   .hreadyout(hreadyout), .hresp(hresp), .instrDone(instrDone), .swiExec(swiExec),
   .waitExec(waitExec), .stopExec(stopExec), .cpuMask(cpuMask), .sysReset(sysReset),
   .intStart(intStart), .intVector(intVector), .stackPcMinus1(stackPcMinus1),
   .stackIndexHigh(stackIndexHigh), .maskClear(maskClear), .cpuClkEn(cpuClkEn),
   .periphClkEn(periphClkEn), .oscClkEn(oscClkEn), .breakState(breakState),
   .flagClrAllow(flagClrAllow), .resetSeq(resetSeq));
`default_nettype wire

// File: dv/siu_core_model.sv
// processor core model: mask bit and stacking
`timescale 1ns/1ns
`default_nettype none
module siu_core_model #(parameter DLY = 3) (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic intStart,
   input  wire logic maskClear,
   input  wire logic maskWr,
   input  wire logic maskVal,
   output var  logic cpuMask,
   output var  logic stackDone
);
   logic [3:0] cnt;
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cpuMask <= 1'b1;
         stackDone <= 1'b0;
         cnt <= 4'h0;
      end else begin
         stackDone <= (cnt == 4'h1);
         if (intStart) cnt <= 4'(DLY);
         else if (cnt != 4'h0) cnt <= cnt - 4'h1;
         if (intStart) cpuMask <= 1'b1;
         else if (maskClear) cpuMask <= 1'b0;
         else if (maskWr) cpuMask <= maskVal;
      end
   end
endmodule
`default_nettype wire

// File: dv/testbench.sv
// testbench for the system integration unit
`timescale 1ns/1ns
`default_nettype none
`include "siu_defines.vh"
module testbench;
   localparam LONG = 64;
   logic        clk = 0, rst_n = 0, haddrSel = 0, hwrite = 0, maskWr = 0, maskVal = 0;
   logic [31:0] haddr = 0, hwdata = 0, rd;
   logic [1:0]  htrans = 0;
   logic        instrDone = 0, swiExec = 0, waitExec = 0, stopExec = 0, rtiExec = 0;
   logic        breakReq = 0, sysReset = 0, flagClrStep1 = 0, flagClrStep2 = 0;
   logic [7:0]  irqReq = 0, irqEn = 0;
   logic [5:0]  resetCause = 0;
   logic [22:0] rows [5];
   wire         hready, hresp, hreadyout, intStart, stackPcMinus1, stackIndexHigh, maskClear;
   wire         cpuClkEn, periphClkEn, oscClkEn, watchdogRun, breakState, flagClrAllow;
   wire         resetSeq, cpuMask, stackDone;
   wire [31:0]  hrdata;
   wire [3:0]   intVector;
   int          error_cnt = 0, comparisons = 0, cyc = 0, n, i;
   assign hready = hreadyout;
   siu_core #(.LONG_CYC(LONG)) siu_core_inst (.clk(clk), .rst_n(rst_n), .haddr_sel(haddrSel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .instrDone(instrDone), .swiExec(swiExec), .waitExec(waitExec), .stopExec(stopExec),
      .rtiExec(rtiExec), .cpuMask(cpuMask), .stackDone(stackDone), .irqReq(irqReq),
      .irqEn(irqEn), .breakReq(breakReq), .resetCause(resetCause), .sysReset(sysReset),
      .flagClrStep1(flagClrStep1), .flagClrStep2(flagClrStep2), .intStart(intStart),
      .intVector(intVector),
      .stackPcMinus1(stackPcMinus1), .stackIndexHigh(stackIndexHigh), .maskClear(maskClear),
      .cpuClkEn(cpuClkEn), .periphClkEn(periphClkEn), .oscClkEn(oscClkEn),
      .watchdogRun(watchdogRun), .breakState(breakState), .flagClrAllow(flagClrAllow),
      .resetSeq(resetSeq));
   siu_core_model siu_core_model_inst (.clk(clk), .rst_n(rst_n), .intStart(intStart),
      .maskClear(maskClear), .maskWr(maskWr), .maskVal(maskVal), .cpuMask(cpuMask),
      .stackDone(stackDone));
   always #25 clk = ~clk;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt++;
         test_done;
      end
   end
   task tick(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   task chk(input [31:0] got, input [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: %h expected %h", $time, got, exp);
      end
   endtask
   task bus(input [31:0] a, input w, input [31:0] d);
      haddrSel <= 1; haddr <= a; htrans <= 2'h2; hwrite <= w;
      tick(1);
      while (hreadyout !== 1'b1) tick(1);
      haddrSel <= 0; htrans <= 2'h0; hwdata <= d;
      tick(1);
      while (hreadyout !== 1'b1) tick(1);
      rd = hrdata;
   endtask
   task waitInt(input int lim);
      n = 0;
      while (intStart !== 1'b1 && n < lim) begin
         tick(1);
         n++;
      end
   endtask
   task setMask(input v);
      maskWr <= 1; maskVal <= v;
      tick(1);
      maskWr <= 0;
   endtask
   task instr(input s, input r);
      instrDone <= 1; swiExec <= s; rtiExec <= r;
      tick(1);
      instrDone <= 0; swiExec <= 0; rtiExec <= 0;
      waitInt(6);
   endtask
   task test_done;
      $display("errors %0d comparisons %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   initial begin
      rows[0] = {8'h0c, 8'hff, 1'b0, 6'h32};
      rows[1] = {8'h0c, 8'h08, 1'b0, 6'h33};
      rows[2] = {8'h81, 8'hff, 1'b0, 6'h30};
      rows[3] = {8'h01, 8'hfe, 1'b0, 6'h00};
      rows[4] = {8'h01, 8'hff, 1'b1, 6'h00};
      tick(5);
      rst_n <= 1;
      tick(1);
      bus(`SIU_OFS_RESET_CAUSE, 0, 0); chk(rd, `SIU_CAUSE_POWER_ON);
      bus(`SIU_OFS_RESET_CAUSE, 0, 0); chk(rd, 0);
      bus(`SIU_OFS_BREAK_WAKE, 0, 0); chk(rd, `SIU_RST_BREAK_WAKE);
      bus(32'h14, 1, 32'h5a); bus(32'h14, 0, 0); chk(rd, 0);
      bus(`SIU_OFS_BREAK_FLAG, 1, 32'h80); bus(`SIU_OFS_BREAK_FLAG, 0, 0); chk(rd, 32'h80);
      bus(`SIU_OFS_BREAK_FLAG, 1, 0);
      for (i = 0; i < 5; i++) begin
         {irqReq, irqEn} <= rows[i][22:7];
         setMask(rows[i][6]);
         tick(3);
         instr(0, 0);
         chk({stackPcMinus1 & intStart, intStart, intStart ? intVector : 4'h0}, rows[i][5:0]);
         irqReq <= 0;
         tick(6);
      end
      setMask(1); instr(1, 0); chk({stackPcMinus1, intStart, intVector}, 6'h1f);
      tick(6);
      irqReq <= 8'h06; irqEn <= 8'hff; setMask(0); tick(3);
      instr(0, 0); chk(intVector, 4'h1);
      irqReq <= 8'h04; tick(6); setMask(0); tick(2);
      instr(0, 1); chk({intStart, intVector}, 5'h12);
      irqReq <= 0; tick(6);
      waitExec <= 1; tick(1); waitExec <= 0; tick(2);
      chk({cpuClkEn, periphClkEn, watchdogRun, cpuMask}, 4'h6);
      irqReq <= 1; irqEn <= 1; waitInt(8);
      chk({intStart, cpuClkEn, n <= 4}, 3'h7);
      irqReq <= 0; tick(6);
      for (i = 0; i < 2; i++) begin
         bus(`SIU_OFS_CONFIG, 1, i);
         stopExec <= 1; tick(1); stopExec <= 0; tick(2);
         chk({periphClkEn, oscClkEn}, 2'h0);
         irqReq <= 1; waitInt(200);
         chk({intStart, n >= (i ? 32 : LONG), n <= (i ? 32 : LONG) + 8}, 3'h7);
         irqReq <= 0; tick(6);
      end
      waitExec <= 1; tick(1); waitExec <= 0; breakReq <= 1; waitInt(8);
      chk({intStart, intVector, stackPcMinus1}, 6'h3e);
      tick(2); chk({breakState, flagClrAllow}, 2'h2);
      flagClrStep1 <= 1; tick(1); flagClrStep1 <= 0; flagClrStep2 <= 1; tick(1);
      flagClrStep2 <= 0;
      bus(`SIU_OFS_STATUS, 0, 0); chk(rd & 32'h20, 32'h20);
      bus(`SIU_OFS_BREAK_FLAG, 1, 32'h80); tick(1); chk(flagClrAllow, 1);
      bus(`SIU_OFS_BREAK_WAKE, 0, 0); chk(rd, 32'h2);
      breakReq <= 0; tick(4);
      bus(`SIU_OFS_BREAK_WAKE, 1, 0); bus(`SIU_OFS_BREAK_WAKE, 0, 0); chk(rd, 0);
      bus(`SIU_OFS_BREAK_FLAG, 1, 0); tick(6);
      instr(0, 1); tick(6); chk({breakState, flagClrAllow}, 2'h1);
      flagClrStep2 <= 1; tick(1); flagClrStep2 <= 0;
      bus(`SIU_OFS_STATUS, 0, 0); chk(rd & 32'h20, 0);
      waitExec <= 1; tick(1); waitExec <= 0; resetCause <= 6'h04; sysReset <= 1; tick(4);
      chk({resetSeq, intStart}, 2'h2);
      sysReset <= 0; tick(6);
      bus(`SIU_OFS_RESET_CAUSE, 0, 0); chk(rd, 32'h4);
      rst_n <= 0; tick(2); rst_n <= 1; tick(1);
      chk({breakState, flagClrAllow, cpuClkEn, periphClkEn, oscClkEn}, 5'h0f);
      bus(`SIU_OFS_RESET_CAUSE, 0, 0); chk(rd, `SIU_CAUSE_POWER_ON);
      test_done;
   end
endmodule
`default_nettype wire
